// ===== src/pta_pkg.sv
// Purpose: Shared constants and carriers for the target termination block
// Assumes: 32-bit bus, one clock (bus clock), active-low bus signals
// Notes: Functional notes follow
package pta_pkg;
	localparam int DATA_W = 32;
	localparam int RETRY_CYCLES = 2;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

	// State of one claimed transaction
	typedef enum logic [4:0] {
		PTA_IDLE = 5'h01,
		PTA_DATA = 5'h02,
		PTA_STOP = 5'h04,
		PTA_WAIT = 5'h08,
		PTA_TURN = 5'h10
	} pta_state_e;

	// Bus side control, all active low
	typedef struct packed {
		logic devsel_n;
		logic trdy_n;
		logic stop_n;
	} pta_bus_ctl_s;

	// Back-end request levels, all active low
	typedef struct packed {
		logic ready_n;
		logic abort_req_n;
		logic disconnect_req_n;
	} pta_be_req_s;
endpackage

// ===== src/pta_delay.sv
// Purpose: Small delay line of a single bit, reset to a given level
// Assumes: Clock enable freezes all stages
// Notes: Used for the ready history of the back-end
`timescale 1ns/1ns
`default_nettype none
module pta_delay #(
	parameter int DEPTH = 2,
	parameter logic RST_VAL = 1'b1
) (
	// Clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic clr,
	// Data
	input wire logic din,
	output logic [DEPTH-1:0] taps
);
	logic [DEPTH-1:0] sh_q;
	logic [DEPTH-1:0] sh_d;

	initial begin
		if (DEPTH < 1) $error("pta_delay depth must be at least one");
	end

	// Shift in, or load idle level on clear; no part-select, so one stage works
	always_comb begin
		sh_d = {DEPTH{RST_VAL}};
		if (!clr) begin
			sh_d = (sh_q << 1) | DEPTH'(din);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sh_q <= {DEPTH{RST_VAL}};
		end else if (ce) begin
			sh_q <= sh_d;
		end
	end

	assign taps = sh_q;
endmodule
`default_nettype wire

// ===== src/pta_target.sv
// Purpose: Target data path and termination for abort and retry
// Assumes: Address decode done outside; hit is a one-cycle pulse
// Notes: Bus control outputs are active low and driven by flip-flops
`timescale 1ns/1ns
`default_nettype none
module pta_target #(
	parameter int DATA_W = pta_pkg::DATA_W,
	parameter int RETRY_CYCLES = pta_pkg::RETRY_CYCLES
) (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	// Bus master side
	input wire logic addr_hit,
	input wire logic is_read,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic [DATA_W-1:0] ad_in,
	output logic [DATA_W-1:0] ad_out,
	output logic ad_oe,
	output pta_pkg::pta_bus_ctl_s bus_ctl,
	output logic bus_ctl_oe,
	// Back-end side
	input wire pta_pkg::pta_be_req_s be_req,
	input wire logic [DATA_W-1:0] backend_read_data,
	output logic backend_xfer_strobe_n,
	output logic [DATA_W-1:0] backend_write_data
);
	logic rst_m_q;
	logic rst_n_q;
	pta_pkg::pta_state_e st_q;
	pta_pkg::pta_state_e st_d;
	pta_pkg::pta_bus_ctl_s ctl_q;
	pta_pkg::pta_bus_ctl_s ctl_d;
	logic rd_q;
	logic rd_d;
	logic strb_q;
	logic strb_d;
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W-1:0] wdata_d;
	logic [1:0] disc_cnt_q;
	logic [1:0] disc_cnt_d;
	logic seen_rdy_q;
	logic seen_rdy_d;
	logic [0:0] rdy_hist;
	logic in_xfer;

	initial begin
		if (DATA_W != 32 && DATA_W != 64) $error("DATA_W must be 32 or 64");
		if (RETRY_CYCLES < 1 || RETRY_CYCLES > 3) $error("bad RETRY_CYCLES");
	end

	// Reset release through two flops; async assert only
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	assign in_xfer = (st_q == pta_pkg::PTA_DATA);

	// Ready of the last cycle; the registered outputs add the second cycle
	pta_delay #(.DEPTH(1), .RST_VAL(1'b1)) u_rdy_hist (
		.clk(clk_sys),
		.rst_n(rst_n_q),
		.ce(ce),
		.clr(!in_xfer),
		.din(be_req.ready_n),
		.taps(rdy_hist)
	);

	// Transaction sequencing and bus control
	always_comb begin
		st_d = st_q;
		ctl_d = ctl_q;
		rd_d = rd_q;
		strb_d = 1'b1;
		rdata_d = rdata_q;
		wdata_d = wdata_q;
		disc_cnt_d = disc_cnt_q;
		seen_rdy_d = seen_rdy_q;
		unique case (st_q)
			pta_pkg::PTA_IDLE: begin
				disc_cnt_d = 2'h0;
				seen_rdy_d = 1'b0;
				if (addr_hit) begin
					st_d = pta_pkg::PTA_DATA;
					ctl_d = '{devsel_n: 1'b0, trdy_n: 1'b1, stop_n: 1'b1};
					rd_d = is_read;
				end
			end
			pta_pkg::PTA_DATA: begin
				if (!be_req.ready_n) begin
					seen_rdy_d = 1'b1;
				end
				// For reads, strobe is registered from ready, so it lands one cycle later
				strb_d = be_req.ready_n;
				// Abort wins over everything; irdy_n is not looked at
				if (!be_req.abort_req_n) begin
					st_d = pta_pkg::PTA_STOP;
					ctl_d = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b0};
					strb_d = 1'b1;
				end else if (rd_q) begin
					ctl_d.trdy_n = rdy_hist[0];
					if (!rdy_hist[0]) begin
						rdata_d = backend_read_data;
					end
				end else begin
					ctl_d.trdy_n = be_req.ready_n & rdy_hist[0];
					if (!ctl_q.trdy_n && !irdy_n) begin
						wdata_d = ad_in;
						strb_d = 1'b0;
					end else begin
						strb_d = 1'b1;
					end
				end
				// Retry when disconnect comes before any ready
				if (be_req.abort_req_n && !seen_rdy_q && be_req.ready_n &&
					!be_req.disconnect_req_n) begin
					disc_cnt_d = disc_cnt_q + 2'h1;
					if (disc_cnt_q == 2'(RETRY_CYCLES - 1)) begin
						st_d = pta_pkg::PTA_WAIT;
						ctl_d = '{devsel_n: 1'b0, trdy_n: 1'b1, stop_n: 1'b0};
					end
				end else if (be_req.disconnect_req_n) begin
					disc_cnt_d = 2'h0;
				end
				// Master ended normally
				if (frame_n && !irdy_n && !ctl_q.trdy_n &&
					st_d == pta_pkg::PTA_DATA) begin
					st_d = pta_pkg::PTA_TURN;
					ctl_d = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1};
				end
			end
			pta_pkg::PTA_STOP, pta_pkg::PTA_WAIT: begin
				// Release stop once frame is seen high; the master drops
				// irdy on that same edge, so both end in one cycle
				if (frame_n) begin
					st_d = pta_pkg::PTA_TURN;
					ctl_d = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1};
				end
			end
			pta_pkg::PTA_TURN: begin
				// One cycle of driven-high before letting go
				st_d = pta_pkg::PTA_IDLE;
			end
			default: begin
				st_d = pta_pkg::PTA_IDLE;
				ctl_d = '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1};
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q <= pta_pkg::PTA_IDLE;
			ctl_q <= '{devsel_n: 1'b1, trdy_n: 1'b1, stop_n: 1'b1};
			rd_q <= 1'b0;
			strb_q <= 1'b1;
			rdata_q <= DATA_W'(pta_pkg::DATA_RST);
			wdata_q <= DATA_W'(pta_pkg::DATA_RST);
			disc_cnt_q <= 2'h0;
			seen_rdy_q <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
			ctl_q <= ctl_d;
			rd_q <= rd_d;
			strb_q <= strb_d;
			rdata_q <= rdata_d;
			wdata_q <= wdata_d;
			disc_cnt_q <= disc_cnt_d;
			seen_rdy_q <= seen_rdy_d;
		end
	end

	// Outputs: control pins driven through the turnaround cycle
	assign bus_ctl = ctl_q;
	assign bus_ctl_oe = (st_q != pta_pkg::PTA_IDLE);
	assign ad_out = rdata_q;
	assign ad_oe = rd_q && in_xfer;
	assign backend_xfer_strobe_n = strb_q;
	assign backend_write_data = wdata_q;

	// Abort: stop asserted and devsel/trdy released next cycle
	abort_response_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && !be_req.abort_req_n) |=>
		(!bus_ctl.stop_n && bus_ctl.devsel_n && bus_ctl.trdy_n))
		else $error("abort not signalled next cycle");

	// Abort takes effect even while irdy_n is high
	abort_no_irdy_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && !be_req.abort_req_n && irdy_n) |=>
		(st_q == pta_pkg::PTA_STOP))
		else $error("abort held off by irdy");

	// Claim follows a hit
	claim_on_hit_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && st_q == pta_pkg::PTA_IDLE && addr_hit) |=> !bus_ctl.devsel_n)
		else $error("devsel not driven on hit");

	// Strobe one cycle after ready
	strobe_after_rdy_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && rd_q && !be_req.ready_n && be_req.abort_req_n)
		|=> !backend_xfer_strobe_n)
		else $error("read strobe missing");

	// Read trdy two cycles after ready
	read_trdy_two_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && rd_q && !be_req.ready_n ##1
		ce && in_xfer && be_req.abort_req_n &&
		!(frame_n && !irdy_n && !bus_ctl.trdy_n)) |=> !bus_ctl.trdy_n)
		else $error("read trdy not two cycles after ready");

	// Read data reaches bus
	read_data_bus_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && rd_q && !rdy_hist[0] && be_req.abort_req_n) |=>
		(ad_out == $past(backend_read_data)))
		else $error("read data not forwarded");

	// Write trdy the cycle after ready
	write_trdy_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && !rd_q && !be_req.ready_n && be_req.abort_req_n &&
		!(frame_n && !irdy_n && !bus_ctl.trdy_n)) |=> !bus_ctl.trdy_n)
		else $error("write trdy late");

	// Write word passed with strobe
	write_pass_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && !rd_q && !bus_ctl.trdy_n && !irdy_n &&
		be_req.abort_req_n) |=>
		(!backend_xfer_strobe_n && backend_write_data == $past(ad_in)))
		else $error("write word not passed");

	// Stop released when master ends
	stop_release_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && st_q == pta_pkg::PTA_STOP && frame_n) |=>
		(bus_ctl.stop_n ##1
		(st_q == pta_pkg::PTA_IDLE || !$past(ce))))
		else $error("stop not released");

	// Retry after disconnect held without ready
	retry_stop_a: assert property (@(posedge clk_sys)
		disable iff (!rst_n_q)
		(ce && in_xfer && !seen_rdy_q && disc_cnt_q == 2'h1 &&
		be_req.ready_n && be_req.abort_req_n && !be_req.disconnect_req_n)
		|=> !bus_ctl.stop_n)
		else $error("retry stop missing");
endmodule
`default_nettype wire

// ===== tb/pta_master_model.sv
// Purpose: Behavioural bus master facing the target block
// Assumes: Start is a one-cycle pulse from the bench
// Notes: Released data lines show the inverse of the last word
`timescale 1ns/1ns
`default_nettype none
module pta_master_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic arst_n,
	// Bench control
	input wire logic start,
	input wire logic hold,
	input wire logic [31:0] wdata,
	// Bus
	input wire pta_pkg::pta_bus_ctl_s bus_ctl,
	output logic addr_hit,
	output logic frame_n,
	output logic irdy_n,
	output logic [31:0] ad_in
);
	logic frame_q;
	logic irdy_q;
	// Frame ends one clock after stop, irdy one clock after frame
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			frame_q <= 1'b1;
			irdy_q <= 1'b1;
		end else if (start) begin
			frame_q <= 1'b0;
			irdy_q <= 1'b0;
		end else if (!frame_q && !bus_ctl.stop_n) begin
			frame_q <= 1'b1;
		end else if (frame_q && !irdy_q) begin
			irdy_q <= 1'b1;
		end
	end
	// Hold adds wait states; idle lines never show the last word
	assign addr_hit = start;
	assign frame_n = frame_q & ~start;
	assign irdy_n = (irdy_q & ~start) | hold;
	assign ad_in = irdy_n ? ~wdata : wdata;
endmodule
`default_nettype wire

// ===== tb/pci_target_abort_termination_bench.sv
// Purpose: Self-checking bench for abort and retry terminations
// Assumes: Inputs change by NBA at the rising edge
// Notes: Checks at an edge see the cycle that just ended
`timescale 1ns/1ns
`default_nettype none
module pci_target_abort_termination_bench;
	logic clk_sys, arst_n, ce, start, hold, is_read;
	logic addr_hit, frame_n, irdy_n, ad_oe, ctl_oe, strobe_n;
	logic [31:0] wdata, rdata, ad_in, ad_out, wr_out;
	pta_pkg::pta_be_req_s be_req;
	pta_pkg::pta_bus_ctl_s bus_ctl;
	int mismatches, tests_run;

	pta_target u_pta_target (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
		.addr_hit(addr_hit), .is_read(is_read), .frame_n(frame_n),
		.irdy_n(irdy_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
		.bus_ctl(bus_ctl), .bus_ctl_oe(ctl_oe), .be_req(be_req),
		.backend_read_data(rdata), .backend_xfer_strobe_n(strobe_n),
		.backend_write_data(wr_out));
	pta_master_model u_pta_master_model (.clk_sys(clk_sys),
		.arst_n(arst_n), .start(start), .hold(hold), .wdata(wdata),
		.bus_ctl(bus_ctl), .addr_hit(addr_hit), .frame_n(frame_n),
		.irdy_n(irdy_n), .ad_in(ad_in));

	// Free-running bus clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task step;
		@(posedge clk_sys);
	endtask

	// Case compare so an unknown never passes
	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task complete_run;
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Read with ready held, abort on the second word; its data is junk
	task read_abort;
		step;
		start <= 1'b1;
		is_read <= 1'b1;
		step;
		start <= 1'b0;
		be_req.ready_n <= 1'b0;
		step;
		chk("rd devsel", bus_ctl.devsel_n, 1'b0);
		rdata <= 32'ha5c3_0f01;
		step;
		chk("rd strobe", strobe_n, 1'b0);
		be_req.abort_req_n <= 1'b0;
		rdata <= 32'h5a3c_f0fe;
		step;
		chk("rd trdy", bus_ctl.trdy_n, 1'b0);
		chk("rd ad_out", ad_out, 32'ha5c3_0f01);
		chk("rd ad_oe", ad_oe, 1'b1);
		be_req.abort_req_n <= 1'b1;
		be_req.ready_n <= 1'b1;
		step;
		chk("rd abort ctl", bus_ctl, 3'b110);
		chk("rd abort strobe", strobe_n, 1'b1);
		chk("rd no junk", ad_out, 32'ha5c3_0f01);
		step;
		chk("rd stop held", bus_ctl.stop_n, 1'b0);
		step;
		chk("rd stop off", bus_ctl, 3'b111);
		step;
		chk("rd idle oe", {ctl_oe, ad_oe}, 2'b00);
	endtask

	// Write abort while the master inserts a wait state
	task write_abort;
		step;
		start <= 1'b1;
		is_read <= 1'b0;
		step;
		start <= 1'b0;
		be_req.ready_n <= 1'b0;
		wdata <= 32'h1234_5678;
		step;
		be_req.ready_n <= 1'b1;
		step;
		chk("wr trdy", bus_ctl.trdy_n, 1'b0);
		wdata <= 32'h8765_4321;
		hold <= 1'b1;
		be_req.abort_req_n <= 1'b0;
		step;
		chk("wr data", wr_out, 32'h1234_5678);
		chk("wr strobe", strobe_n, 1'b0);
		hold <= 1'b0;
		be_req.abort_req_n <= 1'b1;
		step;
		chk("wr abort ctl", bus_ctl, 3'b110);
		step;
		chk("wr no data", strobe_n, 1'b1);
		chk("wr stop held", bus_ctl.stop_n, 1'b0);
		step;
		chk("wr stop off", {bus_ctl, ctl_oe}, 4'hf);
		step;
		chk("wr idle oe", ctl_oe, 1'b0);
	endtask

	// Disconnect without ready gives a retry two clocks later
	task retry_run;
		step;
		start <= 1'b1;
		is_read <= 1'b1;
		step;
		start <= 1'b0;
		be_req.disconnect_req_n <= 1'b0;
		step;
		// A frozen cycle must not count toward the retry
		ce <= 1'b0;
		step;
		ce <= 1'b1;
		chk("rt stop early", bus_ctl.stop_n, 1'b1);
		step;
		chk("rt ce hold", bus_ctl.stop_n, 1'b1);
		be_req.disconnect_req_n <= 1'b1;
		step;
		chk("rt stop", bus_ctl.stop_n, 1'b0);
		chk("rt strobe", strobe_n, 1'b1);
		step;
		chk("rt stop held", bus_ctl, 3'h2);
		step;
		chk("rt stop off", {bus_ctl, ctl_oe}, 4'hf);
		step;
		chk("rt idle", {bus_ctl, ctl_oe}, 4'b1110);
	endtask

	// Main sequence
	initial begin
		arst_n = 1'b0;
		ce = 1'b1;
		start = 1'b0;
		hold = 1'b0;
		is_read = 1'b0;
		wdata = 32'h0;
		rdata = 32'h0;
		be_req = 3'h7;
		mismatches = 0;
		tests_run = 0;
		repeat (12) step;
		arst_n <= 1'b1;
		repeat (4) step;
		read_abort;
		write_abort;
		retry_run;
		complete_run;
	end

	// Reset and the three scenarios need about 43 cycles
	initial begin
		repeat (600) @(posedge clk_sys);
		mismatches++;
		complete_run;
	end
endmodule
`default_nettype wire
